// [hdl/fuse_prog_pkg.sv]
package fuse_prog_pkg;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int WORDS = 32;
    localparam int WIDTH = 8;
    localparam int ADDR_W = 5;

    // ****************************************
    // Timing, in microseconds, and clock rate
    // ****************************************
    localparam int CLK_MHZ = 200;
    localparam int T_STEP_US = 10;      // Pulse sequence delay
    localparam int T_VERIFY_US = 50;    // Supply-off to verify delay
    localparam int T_PULSE_MIN_US = 1000;
    localparam int T_PULSE_MAX_US = 2000;
    localparam int T_REST_US = 4000;    // Rest at zero supply per cycle

    // Derived cycle counts (exact at this rate)
    localparam int STEP_CYC = T_STEP_US * CLK_MHZ;
    localparam int VERIFY_CYC = T_VERIFY_US * CLK_MHZ;
    localparam int PULSE_MIN_CYC = T_PULSE_MIN_US * CLK_MHZ;
    localparam int PULSE_MAX_CYC = T_PULSE_MAX_US * CLK_MHZ;
    localparam int REST_CYC = T_REST_US * CLK_MHZ;

    // Wait counter width, large enough for the rest period
    localparam int TIMER_W = 20;

    // ****************************************
    // Supply level request to the external supply
    // ****************************************
    typedef enum logic [2:0] {
        SUP_OFF = 3'h0,
        SUP_NORM = 3'h1,
        SUP_PROG = 3'h2,
        SUP_HI = 3'h3,
        SUP_LO = 3'h4
    } supply_e;

    // Controller states, one-hot
    typedef enum logic [11:0] {
        S_IDLE = 12'h001,
        S_SEL = 12'h002,
        S_CUR = 12'h004,
        S_PULSE = 12'h008,
        S_HOLD = 12'h010,
        S_DROP = 12'h020,
        S_OFF = 12'h040,
        S_VHI = 12'h080,
        S_VLO = 12'h100,
        S_REST = 12'h200,
        S_GAP = 12'h400,
        S_READ = 12'h800
    } state_e;

    // Everything the controller drives toward the device
    typedef struct packed {
        supply_e supply;
        logic [WIDTH-1:0] fuse_en;
        logic ce_n;
        logic [ADDR_W-1:0] addr;
    } pins_s;

endpackage : fuse_prog_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    // ****************************************
    // Three stages; accept a level once stages two and three agree
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
            end
        end
    endgenerate

    // Register the stages
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end

endmodule : pin_sync

// [hdl/fuse_programmer.sv]
`timescale 1ns/1ps
module fuse_programmer
    import fuse_prog_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_MIN_CYC,
    parameter int VERIFY_DLY_CYC = VERIFY_CYC,
    parameter int REST_DLY_CYC = REST_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic prog_start,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [WIDTH-1:0] prog_bits,
    input wire logic read_start,
    input wire logic [ADDR_W-1:0] read_addr,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [WIDTH-1:0] read_data,
    output logic [ADDR_W-1:0] dev_addr,
    output logic dev_ce_n,
    output supply_e dev_supply,
    output logic [WIDTH-1:0] dev_fuse_en,
    input wire logic [WIDTH-1:0] dev_sense
);

    // ****************************************
    // Declarations
    // ****************************************
    state_e state;
    state_e next_state;
    pins_s pins;
    pins_s next_pins;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [WIDTH-1:0] remain;
    logic [WIDTH-1:0] next_remain;
    logic [WIDTH-1:0] bit_sel;
    logic [WIDTH-1:0] next_bit_sel;
    logic next_busy;
    logic next_done;
    logic next_fail;
    logic [WIDTH-1:0] next_read_data;
    logic [WIDTH-1:0] sense;

    // Lowest set bit of a mask, one-hot
    function automatic logic [WIDTH-1:0] lowest_bit(input logic [WIDTH-1:0] m);
        lowest_bit = m & (~m + 1'b1);
    endfunction : lowest_bit

    // ****************************************
    // Sense comparator outputs come from off chip
    // ****************************************
    pin_sync #(
        .W(WIDTH)
    ) u_sense_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din(dev_sense),
        .dout(sense)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_pins = pins;
        next_timer = (timer != '0) ? timer - 1'b1 : timer;
        next_remain = remain;
        next_bit_sel = bit_sel;
        next_busy = busy;
        next_done = 1'b0;
        next_fail = fail;
        next_read_data = read_data;
        unique case (state)
            S_IDLE:
            begin
                if (prog_start)
                begin
                    next_fail = 1'b0;
                    next_pins.addr = prog_addr;   // address before supply
                    next_remain = prog_bits;      // only requested bits
                    if (prog_bits == '0)
                    begin
                        next_done = 1'b1;
                    end
                    else
                    begin
                        next_timer = TIMER_W'(STEP_CYC);
                        next_busy = 1'b1;
                        next_state = S_SEL;
                    end
                end
                else if (read_start)
                begin
                    next_pins.addr = read_addr;
                    next_pins.supply = SUP_NORM;
                    next_pins.ce_n = 1'b0;        // select gates outputs
                    next_timer = TIMER_W'(STEP_CYC);
                    next_busy = 1'b1;
                    next_state = S_READ;
                end
            end
            S_SEL:
            begin
                // Address already stands one cycle before the supply rises
                if (pins.supply != SUP_PROG)
                begin
                    next_pins.supply = SUP_PROG;  // supply after address
                    next_timer = TIMER_W'(STEP_CYC);
                end
                else if (timer == '0)
                begin
                    next_bit_sel = lowest_bit(remain);
                    next_pins.fuse_en = lowest_bit(remain);  // one output only
                    next_timer = TIMER_W'(STEP_CYC);
                    next_state = S_CUR;
                end
            end
            S_CUR:
            begin
                if (timer == '0)
                begin
                    next_pins.ce_n = 1'b0;        // fusing pulse
                    next_timer = TIMER_W'(PULSE_CYC);
                    next_state = S_PULSE;
                end
            end
            S_PULSE:
            begin
                if (timer == '0)
                begin
                    next_pins.ce_n = 1'b1;
                    next_timer = TIMER_W'(STEP_CYC);
                    next_state = S_HOLD;
                end
            end
            S_HOLD:
            begin
                if (timer == '0)
                begin
                    next_pins.fuse_en = '0;
                    next_timer = TIMER_W'(STEP_CYC);
                    next_state = S_DROP;
                end
            end
            S_DROP:
            begin
                if (timer == '0)
                begin
                    next_pins.supply = SUP_OFF;
                    next_timer = TIMER_W'(VERIFY_DLY_CYC);
                    next_state = S_OFF;
                end
            end
            S_OFF:
            begin
                if (timer == '0)
                begin
                    next_pins.supply = SUP_HI;
                    next_pins.ce_n = 1'b0;
                    next_timer = TIMER_W'(STEP_CYC);
                    next_state = S_VHI;
                end
            end
            S_VHI:
            begin
                if (timer == '0)
                begin
                    if ((sense & bit_sel) == '0)  // must read one
                    begin
                        next_fail = 1'b1;
                        next_pins.supply = SUP_OFF;
                        next_pins.ce_n = 1'b1;
                        next_timer = TIMER_W'(STEP_CYC);
                        next_state = S_GAP;
                    end
                    else
                    begin
                        next_pins.supply = SUP_LO;
                        next_timer = TIMER_W'(STEP_CYC);
                        next_state = S_VLO;
                    end
                end
            end
            S_VLO:
            begin
                if (timer == '0)
                begin
                    next_fail = ((sense & bit_sel) == '0);
                    next_pins.supply = SUP_OFF;   // rest at zero supply
                    next_pins.ce_n = 1'b1;
                    next_remain = remain & ~bit_sel;
                    next_timer = TIMER_W'(REST_DLY_CYC);
                    next_state = S_REST;
                end
            end
            S_REST:
            begin
                if (timer == '0)
                begin
                    if (remain != '0 && !fail)
                    begin
                        next_pins.supply = SUP_PROG;
                        next_timer = TIMER_W'(STEP_CYC);
                        next_state = S_SEL;
                    end
                    else
                    begin
                        next_timer = TIMER_W'(STEP_CYC);
                        next_state = S_GAP;
                    end
                end
            end
            S_GAP:
            begin
                if (timer == '0)
                begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_READ:
            begin
                if (timer == '0)
                begin
                    next_read_data = sense;
                    next_pins.ce_n = 1'b1;
                    next_pins.supply = SUP_OFF;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = S_IDLE;
                end
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
    end

    // Register sequencer state
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            pins <= '{supply: SUP_OFF, fuse_en: '0, ce_n: 1'b1, addr: '0};
            timer <= '0;
            remain <= '0;
            bit_sel <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            read_data <= '0;
        end
        else
        begin
            state <= next_state;
            pins <= next_pins;
            timer <= next_timer;
            remain <= next_remain;
            bit_sel <= next_bit_sel;
            busy <= next_busy;
            done <= next_done;
            fail <= next_fail;
            read_data <= next_read_data;
        end
    end

    // Pins straight from the state register
    assign dev_addr = pins.addr;
    assign dev_ce_n = pins.ce_n;
    assign dev_supply = pins.supply;
    assign dev_fuse_en = pins.fuse_en;

    // ****************************************
    // Checks
    // ****************************************
    logic [TIMER_W-1:0] quiet;
    logic [TIMER_W-1:0] next_quiet;
    state_e prev_state;

    // Cycles since the pins last changed
    always_comb
    begin
        next_quiet = (next_pins != pins) ? '0 : ((&quiet) ? quiet : quiet + 1'b1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            quiet <= '0;
            prev_state <= S_IDLE;
        end
        else
        begin
            quiet <= next_quiet;
            prev_state <= state;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_one_fuse;
        $onehot0(pins.fuse_en);
    endproperty
    a_one_fuse: assert property (p_one_fuse) else $error("several fuses driven");

    property p_fuse_at_prog;
        (pins.fuse_en != '0) |-> (pins.supply == SUP_PROG);
    endproperty
    a_fuse_at_prog: assert property (p_fuse_at_prog) else $error("fuse without prog supply");

    property p_addr_stable;
        (pins.supply != SUP_OFF && $past(pins.supply) != SUP_OFF) |-> $stable(pins.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved while powered");

    property p_step_spacing;
        (pins != $past(pins)) && ($past(state) inside {S_CUR, S_HOLD, S_DROP, S_VHI, S_VLO}
            || ($past(state) == S_SEL && $past(pins.supply) == SUP_PROG))
            |-> $past(quiet) >= STEP_CYC;
    endproperty
    a_step_spacing: assert property (p_step_spacing) else $error("pin step too soon");

    property p_pulse_width;
        $rose(pins.ce_n) && $past(pins.supply) == SUP_PROG
            |-> $past(quiet) >= PULSE_CYC && $past(quiet) <= PULSE_MAX_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("select pulse width wrong");

    property p_pulse_with_current;
        (!pins.ce_n && pins.supply == SUP_PROG) |-> (pins.fuse_en != '0);
    endproperty
    a_pulse_with_current: assert property (p_pulse_with_current) else $error("pulse w/o current");

    property p_verify_delay;
        (pins.supply == SUP_HI && $past(pins.supply) == SUP_OFF) |-> $past(quiet) >= VERIFY_DLY_CYC;
    endproperty
    a_verify_delay: assert property (p_verify_delay) else $error("verify too soon");

    property p_lower_after_upper;
        (pins.supply == SUP_LO) |-> $past(pins.supply) inside {SUP_HI, SUP_LO};
    endproperty
    a_lower_after_upper: assert property (p_lower_after_upper) else $error("lower before upper");

    property p_rest;
        (pins.supply == SUP_PROG && $past(state) == S_REST) |-> $past(quiet) >= REST_DLY_CYC;
    endproperty
    a_rest: assert property (p_rest) else $error("rest period too short");

    property p_verify_fail;
        (state == S_VHI && timer == '0 && (sense & bit_sel) == '0) |=> fail && state == S_GAP;
    endproperty
    a_verify_fail: assert property (p_verify_fail) else $error("missed verify failure");

    property p_done_clears_busy;
        $fell(busy) |-> done;
    endproperty
    a_done_clears_busy: assert property (p_done_clears_busy) else $error("busy fell without done");

    c_program: cover property (state == S_REST ##1 state == S_SEL);
    c_fail: cover property ($rose(fail));
    c_read: cover property (state == S_READ ##1 state == S_IDLE);
    c_done: cover property (done && !fail && prev_state == S_GAP);

endmodule : fuse_programmer

// [verif/fuse_prom_model.sv]
`timescale 1ns/1ps
module fuse_prom_model
    import fuse_prog_pkg::*;
#(
    parameter int PMIN = 20,
    parameter int PMAX = 40,
    parameter int VDLY = 30,
    parameter int RDLY = 40
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] dev_addr,
    input wire logic dev_ce_n,
    input wire logic [2:0] dev_supply,
    input wire logic [WIDTH-1:0] dev_fuse_en,
    input wire logic stuck_open,
    input wire logic [WIDTH-1:0] marginal,
    output logic [WIDTH-1:0] dev_sense,
    output int violations
);
    logic [WIDTH-1:0] mem [WORDS];
    logic [WIDTH-1:0] junk;
    logic [WIDTH-1:0] word;
    pins_s now_p;
    pins_s last;
    supply_e prev_on;
    int gap;

    // ********
    // Fuse array and outputs
    // ********
    // Virgin array reads all zero
    initial
    begin
        foreach (mem[i]) mem[i] = '0;
        last = '0;
        last.ce_n = 1'b1;
        prev_on = SUP_OFF;
        gap = 0;
        violations = 0;
        junk = 8'h5a;
    end

    // Comparator view of outputs; unpowered outputs give garbage
    always_comb
    begin
        word = mem[dev_addr] | dev_fuse_en;
        if (dev_supply == SUP_LO)
            word = word & ~marginal;
        if (dev_supply == SUP_OFF)
            dev_sense = junk;
        else if (dev_ce_n)
            dev_sense = 8'hff; // Released, pulled up
        else
            dev_sense = word;
    end

    task automatic flag(input int code);
        violations++;
        $display("unexpected pin sequence %h at %0t", code, $time);
    endtask : flag

    // ********
    // Fusing and sequence watch
    // ********
    // Gap is the number of cycles the previous pin state stood
    always @(posedge ref_clk)
    begin
        junk <= ~junk;
        now_p = '{supply: supply_e'(dev_supply), fuse_en: dev_fuse_en,
                  ce_n: dev_ce_n, addr: dev_addr};
        if (rst_n && now_p != last)
        begin
            if (!$onehot0(now_p.fuse_en))
                flag(1);
            if (now_p.fuse_en != 0 && now_p.supply != SUP_PROG)
                flag(2);
            if (now_p.fuse_en != last.fuse_en && gap < STEP_CYC)
                flag(3);
            if (now_p.ce_n != last.ce_n && now_p.supply == SUP_PROG)
            begin
                if (!now_p.ce_n && gap < STEP_CYC)
                    flag(4);
                if (now_p.ce_n && (gap < PMIN || gap > PMAX))
                    flag(5);
            end
            if (last.supply == SUP_PROG && now_p.supply != SUP_PROG
                && (now_p.supply != SUP_OFF || gap < STEP_CYC))
                flag(6);
            if (now_p.supply == SUP_HI && last.supply == SUP_OFF && gap < VDLY)
                flag(7);
            if (now_p.supply == SUP_PROG && prev_on == SUP_LO && gap < RDLY)
                flag(8);
            if (now_p.supply == SUP_PROG && now_p.addr != last.addr)
                flag(9);
        end
        if (now_p.supply == SUP_PROG && !now_p.ce_n && $onehot(now_p.fuse_en)
            && !stuck_open)
            mem[dev_addr] = mem[dev_addr] | dev_fuse_en;
        if (now_p != last)
        begin
            if (now_p.supply != SUP_OFF)
                prev_on = now_p.supply;
            gap = 1;
            last = now_p;
        end
        else
            gap++;
    end
endmodule : fuse_prom_model

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import fuse_prog_pkg::*;

    localparam int P_CYC = 20;
    localparam int V_CYC = 30;
    localparam int R_CYC = 40;

    logic ref_clk;
    logic rst_n;
    logic prog_start;
    logic [ADDR_W-1:0] prog_addr;
    logic [WIDTH-1:0] prog_bits;
    logic read_start;
    logic [ADDR_W-1:0] read_addr;
    logic busy;
    logic done;
    logic fail;
    logic [WIDTH-1:0] read_data;
    logic [ADDR_W-1:0] dev_addr;
    logic dev_ce_n;
    supply_e dev_supply;
    logic [WIDTH-1:0] dev_fuse_en;
    logic [WIDTH-1:0] dev_sense;
    logic stuck_open;
    logic [WIDTH-1:0] marginal;
    int violations;
    int miscompares;
    int n_checks;

    fuse_programmer #(.PULSE_CYC(P_CYC), .VERIFY_DLY_CYC(V_CYC), .REST_DLY_CYC(R_CYC)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .prog_start(prog_start),
        .prog_addr(prog_addr), .prog_bits(prog_bits), .read_start(read_start),
        .read_addr(read_addr), .busy(busy), .done(done), .fail(fail),
        .read_data(read_data), .dev_addr(dev_addr), .dev_ce_n(dev_ce_n),
        .dev_supply(dev_supply), .dev_fuse_en(dev_fuse_en), .dev_sense(dev_sense)
    );

    fuse_prom_model #(.PMIN(P_CYC), .PMAX(2 * P_CYC), .VDLY(V_CYC), .RDLY(R_CYC)) prom (
        .ref_clk(ref_clk), .rst_n(rst_n), .dev_addr(dev_addr), .dev_ce_n(dev_ce_n),
        .dev_supply(dev_supply), .dev_fuse_en(dev_fuse_en), .stuck_open(stuck_open),
        .marginal(marginal), .dev_sense(dev_sense), .violations(violations)
    );

    // Free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic issue(input logic p, input logic r, input logic [ADDR_W-1:0] a,
                         input logic [WIDTH-1:0] b);
        tick();
        prog_start = p;
        read_start = r;
        prog_addr = a;
        read_addr = a;
        prog_bits = b;
        tick();
        prog_start = 1'b0;
        read_start = 1'b0;
    endtask : issue

    task automatic wait_done(input int bound, output int n);
        n = 0;
        while (done !== 1'b1)
        begin
            if (n >= bound)
            begin
                miscompares++;
                $display("unexpected hang at %0t: got %h expected %h", $time, n, bound);
                report_and_stop();
            end
            tick();
            n++;
        end
    endtask : wait_done

    // ********
    // Scenarios
    // ********
    task automatic t_read(input logic [ADDR_W-1:0] a, input logic [WIDTH-1:0] exp);
        int n;
        issue(1'b0, 1'b1, a, 8'h00);
        check({dev_ce_n, dev_addr}, {1'b0, a});
        check(dev_supply, SUP_NORM);
        wait_done(STEP_CYC + 10, n);
        check(n, STEP_CYC + 1);
        check(read_data, exp);
        check(dev_ce_n, 1'b1);
    endtask : t_read

    task automatic t_program(input logic [ADDR_W-1:0] a, input logic [WIDTH-1:0] b,
                             input logic exp_fail);
        int n;
        issue(1'b1, 1'b0, a, b);
        check({busy, dev_addr, dev_fuse_en}, {1'b1, a, 8'h00});
        check(dev_supply, SUP_OFF);
        tick();
        check({dev_addr, dev_supply}, {a, SUP_PROG});
        repeat (STEP_CYC + 1) tick();
        check(dev_fuse_en, b & (~b + 8'h01));
        wait_done(30000, n);
        check(fail, exp_fail);
        check(dev_supply, SUP_OFF);
    endtask : t_program

    task automatic t_no_bits(input logic [WIDTH-1:0] old);
        int n;
        issue(1'b1, 1'b1, 5'h02, 8'h00);
        check(busy, 1'b0);
        wait_done(4, n);
        check(n, 0);
        check({fail, read_data}, {1'b0, old});
    endtask : t_no_bits

    task automatic t_refused;
        int n;
        issue(1'b0, 1'b1, 5'h05, 8'h00);
        tick();
        prog_start = 1'b1;
        prog_addr = 5'h03;
        prog_bits = 8'h01;
        repeat (10) tick();
        prog_start = 1'b0;
        wait_done(STEP_CYC, n);
        check(read_data, 8'h81);
        repeat (3) tick();
        check({busy, dev_fuse_en}, 9'h000);
        t_read(5'h03, 8'h00);
    endtask : t_refused

    // ********
    // Main sequence
    // ********
    initial
    begin
        rst_n = 1'b0;
        prog_start = 1'b0;
        read_start = 1'b0;
        prog_addr = 5'h00;
        read_addr = 5'h00;
        prog_bits = 8'h00;
        stuck_open = 1'b0;
        marginal = 8'h00;
        miscompares = 0;
        n_checks = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        check({busy, done, fail, dev_ce_n, dev_supply}, {4'b0001, SUP_OFF});
        check({read_data, dev_fuse_en}, 16'h0000);
        t_read(5'h05, 8'h00);
        t_program(5'h05, 8'h81, 1'b0);
        t_read(5'h05, 8'h81);
        t_read(5'h04, 8'h00);
        stuck_open = 1'b1;
        t_program(5'h09, 8'h10, 1'b1);
        stuck_open = 1'b0;
        t_read(5'h09, 8'h00);
        t_no_bits(8'h00);
        marginal = 8'h04;
        t_program(5'h1f, 8'h04, 1'b1);
        marginal = 8'h00;
        t_read(5'h1f, 8'h04);
        t_refused();
        check(violations, 0);
        report_and_stop();
    end
endmodule : testbench
